// >>> rtl/fc_cfg.svh
`ifndef FC_CFG_SVH
`define FC_CFG_SVH

// register byte offsets, one aligned 32-bit word each
`define FC_OFS_ADDR_LOW 5'h00
`define FC_OFS_ADDR_HIGH 5'h04
`define FC_OFS_DATA_LOW 5'h08
`define FC_OFS_DATA_HIGH 5'h0C
`define FC_OFS_CONTROL 5'h10
`define FC_OFS_UNLOCK_KEY 5'h14

// flash_control bit positions
`define FC_CTL_READ_GO 0
`define FC_CTL_PROG_GO 1
`define FC_CTL_PROG_EN 2
`define FC_CTL_FAULT 3
`define FC_CTL_ROW_ERASE 4
`define FC_CTL_LATCH_ONLY 5
`define FC_CTL_CFG_SEL 6

// unlock key values
`define FC_KEY_FIRST 8'h55
`define FC_KEY_SECOND 8'hAA

// flash geometry
`define FC_LATCHES 16
`define FC_LATCH_BLANK 14'h3FFF

// timing
`define FC_CLK_HZ 10000000
`define FC_SETUP_CYC 2
`define FC_ERASE_TIME_US 2000
`define FC_PROG_TIME_US 2000
`define FC_ERASE_CYC (`FC_ERASE_TIME_US * (`FC_CLK_HZ / 1000000))
`define FC_PROG_CYC (`FC_PROG_TIME_US * (`FC_CLK_HZ / 1000000))

`endif

// >>> rtl/fc_pkg.sv
package fc_pkg;
	typedef enum logic [1:0] {KEY_IDLE, KEY_GOT_FIRST, KEY_ARMED} key_state_e;
	typedef enum logic [1:0] {OP_IDLE, OP_SETUP, OP_BUSY} op_state_e;
	typedef enum logic [1:0] {KIND_LOAD, KIND_PROGRAM, KIND_ERASE} op_kind_e;
	typedef logic [13:0] word_t;
	typedef logic [10:0] row_t;
endpackage

// >>> rtl/flash_row_erase_write_ctrl.sv
// Functional notes
// - flash erase while running is whole rows only, never a single word.
// - erase picks the row holding the address pair; any address in it works.
// - go is followed by two setup cycles; hardware forces two no-ops there.
// - row erase stalls the core about 2 ms; clocks and peripherals keep running.
// - after erase the core resumes at the third instruction after the go set.
// - programming never erases; target words must already be blank.
// - one program operation writes at most sixteen words, one per latch.
// - upper 11 address bits pick the row, lowest 4 bits pick the latch.
// - programming never crosses the row; all latches map into one row.
// - every finished program or erase resets all latches to 3FFFh.
// - latches not loaded before programming keep the blank value.
// - latch-only set: unlock plus go copies data pair into addressed latch only.
// - latch-only clear: unlock plus go loads final word then programs the row.
// - an interrupted key and go sequence starts no load and no programming.
// - a latch-only load forces two no-op cycles and then no stall.
// - programming stalls the core until done, then third instruction after go.
// - software only sets go and read-start; hardware clears them when done.
// - a reset that interrupts program or erase sets the fault flag.
// - the unlock key register is write-only and reads as zero.
// - power-up clears the program enable, so nothing writes until it is set.
`include "fc_cfg.svh"

module flash_row_erase_write_ctrl #(
	parameter int unsigned LATCHES = `FC_LATCHES,
	parameter int unsigned ERASE_CYC = `FC_ERASE_CYC,
	parameter int unsigned PROG_CYC = `FC_PROG_CYC,
	parameter int unsigned TIMER_W = 16
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic sys_reset_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [4:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic core_stall_o,
	output logic force_nop_o,
	output logic read_req_o,
	output logic [14:0] flash_addr_o,
	output logic nv_erase_o,
	output logic nv_program_o,
	output fc_pkg::row_t nv_row_o,
	output logic [LATCHES*14-1:0] nv_wdata_o
);
	import fc_pkg::*;

	localparam int unsigned SEL_W = $clog2(LATCHES);

	logic ack_q;
	logic [31:0] rdata_q;
	logic [7:0] addr_low_q;
	logic [6:0] addr_high_q;
	logic [7:0] data_low_q;
	logic [5:0] data_high_q;
	logic read_go_q;
	logic prog_go_q;
	logic prog_en_q;
	logic fault_q;
	logic row_erase_q;
	logic latch_only_q;
	logic cfg_sel_q;
	key_state_e key_q;
	op_state_e op_q;
	op_kind_e kind_q;
	logic [TIMER_W-1:0] cnt_q;
	row_t row_q;
	word_t latch_q [LATCHES];

	logic req;
	logic wr_fire;
	logic ctl_wr;
	logic key_wr;
	logic go_req;
	logic go_ok;
	logic op_done;
	logic setup_last;
	logic [SEL_W-1:0] latch_sel;

	// bus handshake: one wait state, ack stands one cycle
	assign req = wb_cyc_i && wb_stb_i;
	assign wr_fire = req && wb_we_i && ack_q && wb_sel_i[0];
	assign ctl_wr = wr_fire && (wb_adr_i == `FC_OFS_CONTROL);
	assign key_wr = wr_fire && (wb_adr_i == `FC_OFS_UNLOCK_KEY);
	assign go_req = ctl_wr && wb_dat_i[`FC_CTL_PROG_GO];
	// disabled or config-space go is dropped whole
	assign go_ok = go_req && (key_q == KEY_ARMED) && (op_q == OP_IDLE)
		&& wb_dat_i[`FC_CTL_PROG_EN] && !wb_dat_i[`FC_CTL_CFG_SEL];
	assign setup_last = (op_q == OP_SETUP) && (cnt_q == TIMER_W'(`FC_SETUP_CYC - 1));
	assign op_done = (op_q == OP_BUSY) && (cnt_q == '0);
	assign latch_sel = addr_low_q[SEL_W-1:0];
	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdata_q;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req && !ack_q;
		end
	end

	// read data registered in the wait state; unmapped reads answer zero
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_q <= 32'h0000_0000;
		end else if (req && !ack_q) begin
			case (wb_adr_i)
				`FC_OFS_ADDR_LOW: rdata_q <= {24'h000000, addr_low_q};
				`FC_OFS_ADDR_HIGH: rdata_q <= {24'h000000, 1'b1, addr_high_q};
				`FC_OFS_DATA_LOW: rdata_q <= {24'h000000, data_low_q};
				`FC_OFS_DATA_HIGH: rdata_q <= {24'h000000, 2'b00, data_high_q};
				`FC_OFS_CONTROL: rdata_q <= {24'h000000, 1'b0, cfg_sel_q, latch_only_q,
					row_erase_q, fault_q, prog_en_q, prog_go_q, read_go_q};
				`FC_OFS_UNLOCK_KEY: rdata_q <= 32'h0000_0000;
				default: rdata_q <= 32'h0000_0000;
			endcase
		end
	end

	// address pair; a system reset clears it as well
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			addr_low_q <= 8'h00;
			addr_high_q <= 7'h00;
		end else if (sys_reset_i) begin
			addr_low_q <= 8'h00;
			addr_high_q <= 7'h00;
		end else if (wr_fire && wb_adr_i == `FC_OFS_ADDR_LOW) begin
			addr_low_q <= wb_dat_i[7:0];
		end else if (wr_fire && wb_adr_i == `FC_OFS_ADDR_HIGH) begin
			addr_high_q <= wb_dat_i[6:0];
		end
	end

	// data pair keeps its value over system resets
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			data_low_q <= 8'h00;
			data_high_q <= 6'h00;
		end else if (wr_fire && wb_adr_i == `FC_OFS_DATA_LOW) begin
			data_low_q <= wb_dat_i[7:0];
		end else if (wr_fire && wb_adr_i == `FC_OFS_DATA_HIGH) begin
			data_high_q <= wb_dat_i[5:0];
		end
	end

	// control bits; go and read-start can only be set by software
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			prog_en_q <= 1'b0;
			row_erase_q <= 1'b0;
			latch_only_q <= 1'b0;
			cfg_sel_q <= 1'b0;
			read_go_q <= 1'b0;
			prog_go_q <= 1'b0;
		end else if (sys_reset_i) begin
			prog_en_q <= 1'b0;
			row_erase_q <= 1'b0;
			latch_only_q <= 1'b0;
			cfg_sel_q <= 1'b0;
			read_go_q <= 1'b0;
			prog_go_q <= 1'b0;
		end else begin
			if (ctl_wr) begin
				prog_en_q <= wb_dat_i[`FC_CTL_PROG_EN];
				row_erase_q <= wb_dat_i[`FC_CTL_ROW_ERASE];
				latch_only_q <= wb_dat_i[`FC_CTL_LATCH_ONLY];
				cfg_sel_q <= wb_dat_i[`FC_CTL_CFG_SEL];
			end
			// read path lives elsewhere; one request cycle then self-clear
			if (ctl_wr && wb_dat_i[`FC_CTL_READ_GO] && !read_go_q) begin
				read_go_q <= 1'b1;
			end else begin
				read_go_q <= 1'b0;
			end
			if (go_ok) begin
				prog_go_q <= 1'b1;
			end else if ((setup_last && kind_q == KIND_LOAD) || op_done) begin
				prog_go_q <= 1'b0;
			end
		end
	end

	// fault survives system reset; the set wins over a software clear
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			fault_q <= 1'b0;
		end else if (sys_reset_i && op_q != OP_IDLE && kind_q != KIND_LOAD) begin
			fault_q <= 1'b1;
		end else if (ctl_wr) begin
			fault_q <= wb_dat_i[`FC_CTL_FAULT];
		end
	end

	// unlock key: any write that breaks the 55h, AAh, go chain disarms
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			key_q <= KEY_IDLE;
		end else if (sys_reset_i) begin
			key_q <= KEY_IDLE;
		end else if (wr_fire) begin
			case (key_q)
				KEY_IDLE: begin
					if (key_wr && wb_dat_i[7:0] == `FC_KEY_FIRST) begin
						key_q <= KEY_GOT_FIRST;
					end
				end
				KEY_GOT_FIRST: begin
					if (key_wr && wb_dat_i[7:0] == `FC_KEY_SECOND) begin
						key_q <= KEY_ARMED;
					end else if (key_wr && wb_dat_i[7:0] == `FC_KEY_FIRST) begin
						key_q <= KEY_GOT_FIRST;
					end else begin
						key_q <= KEY_IDLE;
					end
				end
				KEY_ARMED: key_q <= KEY_IDLE;
				default: key_q <= KEY_IDLE;
			endcase
		end
	end

	// sequencer: two forced no-op cycles, then stall for erase or program
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			op_q <= OP_IDLE;
			kind_q <= KIND_LOAD;
			cnt_q <= '0;
			row_q <= '0;
		end else if (sys_reset_i) begin
			op_q <= OP_IDLE;
			cnt_q <= '0;
		end else begin
			case (op_q)
				OP_IDLE: begin
					if (go_ok) begin
						op_q <= OP_SETUP;
						cnt_q <= '0;
						row_q <= {addr_high_q, addr_low_q[7:SEL_W]};
						if (wb_dat_i[`FC_CTL_ROW_ERASE]) begin
							kind_q <= KIND_ERASE;
						end else if (wb_dat_i[`FC_CTL_LATCH_ONLY]) begin
							kind_q <= KIND_LOAD;
						end else begin
							kind_q <= KIND_PROGRAM;
						end
					end
				end
				OP_SETUP: begin
					if (setup_last && kind_q == KIND_LOAD) begin
						op_q <= OP_IDLE;
					end else if (setup_last && kind_q == KIND_ERASE) begin
						op_q <= OP_BUSY;
						cnt_q <= TIMER_W'(ERASE_CYC - 1);
					end else if (setup_last) begin
						op_q <= OP_BUSY;
						cnt_q <= TIMER_W'(PROG_CYC - 1);
					end else begin
						cnt_q <= cnt_q + 1'b1;
					end
				end
				OP_BUSY: begin
					if (op_done) begin
						op_q <= OP_IDLE;
					end else begin
						cnt_q <= cnt_q - 1'b1;
					end
				end
				default: op_q <= OP_IDLE;
			endcase
		end
	end

	// write latches: one word per latch, blank again after every finished program or erase
	genvar gi;
	generate
		for (gi = 0; gi < LATCHES; gi++) begin : g_latch
			always_ff @(posedge clk_i or negedge nrst_i) begin
				if (!nrst_i) begin
					latch_q[gi] <= `FC_LATCH_BLANK;
				end else if (op_done) begin
					latch_q[gi] <= `FC_LATCH_BLANK;
				end else if (go_ok && !wb_dat_i[`FC_CTL_ROW_ERASE]
					&& latch_sel == SEL_W'(gi)) begin
					latch_q[gi] <= {data_high_q, data_low_q};
				end
			end
			assign nv_wdata_o[gi*14 +: 14] = latch_q[gi];
		end
	endgenerate

	// programming only writes latch contents; no erase pulse rides along
	assign nv_erase_o = (op_q == OP_BUSY) && (kind_q == KIND_ERASE);
	assign nv_program_o = (op_q == OP_BUSY) && (kind_q == KIND_PROGRAM);
	assign nv_row_o = row_q;
	assign force_nop_o = (op_q == OP_SETUP);
	// clocks keep running; only instruction fetch halts
	assign core_stall_o = (op_q == OP_BUSY);
	assign read_req_o = read_go_q;
	assign flash_addr_o = {addr_high_q, addr_low_q};

	sequence s_go;
		go_ok;
	endsequence

	sequence s_setup_two;
		force_nop_o [*2];
	endsequence

	a_setup_two_nops: assert property (@(posedge clk_i) disable iff (!nrst_i || sys_reset_i)
		s_go |=> s_setup_two ##1 !force_nop_o)
		else $error("go not followed by exactly two forced no-op cycles");

	a_load_no_stall: assert property (@(posedge clk_i) disable iff (!nrst_i || sys_reset_i)
		s_go ##0 wb_dat_i[`FC_CTL_LATCH_ONLY]
		##0 !wb_dat_i[`FC_CTL_ROW_ERASE] |=> s_setup_two ##1 !core_stall_o)
		else $error("latch-only load stalled the core");

	a_prog_stalls: assert property (@(posedge clk_i) disable iff (!nrst_i || sys_reset_i)
		s_go ##0 !wb_dat_i[`FC_CTL_LATCH_ONLY] |=> s_setup_two ##1 core_stall_o)
		else $error("program or erase did not stall after setup");

	a_no_go_disabled: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(go_req && !wb_dat_i[`FC_CTL_PROG_EN] && op_q == OP_IDLE) |=> op_q == OP_IDLE)
		else $error("operation started with program enable clear");

	a_key_needed: assert property (@(posedge clk_i) disable iff (!nrst_i || sys_reset_i)
		(go_req && key_q != KEY_ARMED && op_q == OP_IDLE) |=> op_q == OP_IDLE)
		else $error("sequencer left idle without key");

	a_armed_by_key: assert property (@(posedge clk_i) disable iff (!nrst_i || sys_reset_i)
		(op_q == OP_IDLE && !go_ok) |=> op_q == OP_IDLE)
		else $error("sequencer started without a full key and go");

	a_latch_blank: assert property (@(posedge clk_i) disable iff (!nrst_i || sys_reset_i)
		op_done |=> latch_q[0] == `FC_LATCH_BLANK && latch_q[LATCHES-1] == `FC_LATCH_BLANK)
		else $error("latches not blank after operation");

	a_go_clears: assert property (@(posedge clk_i) disable iff (!nrst_i || sys_reset_i)
		op_done |=> !prog_go_q && !core_stall_o)
		else $error("go bit not cleared at completion");

	a_key_reads_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(req && !ack_q && !wb_we_i && wb_adr_i == `FC_OFS_UNLOCK_KEY)
		|=> wb_ack_o && rdata_q == 32'h0000_0000)
		else $error("unlock key read not zero");

	a_fault_on_reset: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(sys_reset_i && op_q == OP_BUSY) |=> fault_q && op_q == OP_IDLE)
		else $error("interrupted operation did not flag a fault");

	a_row_stable: assert property (@(posedge clk_i) disable iff (!nrst_i)
		core_stall_o && $past(core_stall_o) |-> $stable(nv_row_o))
		else $error("row changed during operation");

	a_erase_row_only: assert property (@(posedge clk_i) disable iff (!nrst_i)
		nv_erase_o |-> !nv_program_o && kind_q == KIND_ERASE)
		else $error("erase not a whole-row operation");

endmodule

// >>> tb/tb_top.sv
`include "fc_cfg.svh"

module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import fc_pkg::*;
	localparam int unsigned ECYC = 8;
	localparam int unsigned PCYC = 10;
	localparam logic [4:0] A_LO = `FC_OFS_ADDR_LOW;
	localparam logic [4:0] A_HI = `FC_OFS_ADDR_HIGH;
	localparam logic [4:0] D_LO = `FC_OFS_DATA_LOW;
	localparam logic [4:0] D_HI = `FC_OFS_DATA_HIGH;
	localparam logic [4:0] CTL = `FC_OFS_CONTROL;
	localparam logic [4:0] KEY = `FC_OFS_UNLOCK_KEY;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic sys_reset_i = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [4:0] wb_adr_i = 5'h00;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o, core_stall_o, force_nop_o, read_req_o, nv_erase_o, nv_program_o;
	logic [14:0] flash_addr_o;
	row_t nv_row_o;
	logic [223:0] nv_wdata_o, snap;
	logic [31:0] d;
	int n_mismatch = 0;
	int n_compared = 0;
	int n_nop, n_stall, n_prog, n_ers, cycles = 0;

	flash_row_erase_write_ctrl #(.LATCHES(16), .ERASE_CYC(ECYC), .PROG_CYC(PCYC),
		.TIMER_W(16)) flash_row_erase_write_ctrl_i (.clk_i(clk_i), .nrst_i(nrst_i),
		.sys_reset_i(sys_reset_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .core_stall_o(core_stall_o), .force_nop_o(force_nop_o),
		.read_req_o(read_req_o), .flash_addr_o(flash_addr_o), .nv_erase_o(nv_erase_o),
		.nv_program_o(nv_program_o), .nv_row_o(nv_row_o), .nv_wdata_o(nv_wdata_o));

	always #50 clk_i = ~clk_i;

	task automatic conclude;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// generous ceiling: the whole sequence needs well under 1000 cycles
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			n_mismatch++;
			conclude;
		end
	end

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %0h seen %0h", nm, exp, got);
		end
	endtask

	function automatic logic [31:0] lat(input logic [223:0] v, input int i);
		return {18'h0, v[i*14+:14]};
	endfunction

	// request held until ack is seen high at a rising edge; data taken there
	task automatic bus(input logic we, input logic [4:0] adr, input logic [7:0] dat,
		output logic [31:0] rd);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= {24'h0, dat};
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask

	task automatic wr(input logic [4:0] adr, input logic [7:0] dat);
		logic [31:0] x;
		bus(1'b1, adr, dat, x);
	endtask

	task automatic rd(input logic [4:0] adr);
		bus(1'b0, adr, 8'h00, d);
	endtask

	task automatic key(input logic [7:0] ctl);
		wr(KEY, 8'h55);
		wr(KEY, 8'hAA);
		wr(CTL, ctl);
	endtask

	task automatic watch(input int n);
		n_nop = 0;
		n_stall = 0;
		n_prog = 0;
		n_ers = 0;
		repeat (n) begin
			@(negedge clk_i);
			n_nop += (force_nop_o === 1'b1);
			n_stall += (core_stall_o === 1'b1);
			n_ers += (nv_erase_o === 1'b1);
			if (nv_program_o === 1'b1) begin
				if (n_prog == 0) snap = nv_wdata_o;
				n_prog++;
			end
		end
	endtask

	task automatic all_blank;
		for (int i = 0; i < 16; i++) chk("latch", 32'h3FFF, lat(nv_wdata_o, i));
	endtask

	initial begin
		repeat (3) @(posedge clk_i);
		nrst_i <= 1'b1;
		rd(CTL);
		chk("control", 32'h0, d);
		all_blank;
		wr(KEY, 8'h55);
		rd(KEY);
		chk("unlock_key", 32'h0, d);
		rd(5'h18);
		chk("unmapped", 32'h0, d);
		wr(A_HI, 8'h12);
		wr(A_LO, 8'h33);
		wr(D_LO, 8'h34);
		wr(D_HI, 8'h12);
		// go with enable clear must do nothing
		key(8'h22);
		watch(6);
		chk("force_nop", 0, n_nop);
		chk("latch3", 32'h3FFF, lat(nv_wdata_o, 3));
		key(8'h66);
		watch(6);
		chk("force_nop", 0, n_nop);
		chk("latch3", 32'h3FFF, lat(nv_wdata_o, 3));
		key(8'h26);
		watch(6);
		chk("force_nop", 2, n_nop);
		chk("stall", 0, n_stall + n_prog);
		chk("latch3", 32'h1234, lat(nv_wdata_o, 3));
		chk("flash_addr", 32'h1233, {17'h0, flash_addr_o});
		rd(CTL);
		chk("control", 32'h24, d);
		// stray write inside the key sequence
		wr(A_LO, 8'h34);
		wr(KEY, 8'h55);
		wr(D_LO, 8'h56);
		wr(KEY, 8'hAA);
		wr(CTL, 8'h26);
		watch(6);
		chk("force_nop", 0, n_nop);
		chk("latch4", 32'h3FFF, lat(nv_wdata_o, 4));
		wr(A_LO, 8'h3F);
		wr(D_LO, 8'h78);
		key(8'h06);
		watch(PCYC + 8);
		chk("force_nop", 2, n_nop);
		chk("stall", PCYC, n_stall);
		chk("program", PCYC, n_prog);
		chk("erase", 0, n_ers);
		chk("row", 32'h123, {21'h0, nv_row_o});
		chk("latch3", 32'h1234, lat(snap, 3));
		chk("latch15", 32'h1278, lat(snap, 15));
		chk("latch5", 32'h3FFF, lat(snap, 5));
		all_blank;
		rd(CTL);
		chk("control", 32'h04, d);
		wr(A_LO, 8'h33);
		wr(D_LO, 8'h9A);
		key(8'h26);
		wr(A_LO, 8'h57);
		key(8'h16);
		watch(ECYC + 8);
		chk("force_nop", 2, n_nop);
		chk("stall", ECYC, n_stall);
		chk("erase", ECYC, n_ers);
		chk("program", 0, n_prog);
		chk("row", 32'h125, {21'h0, nv_row_o});
		all_blank;
		wr(CTL, 8'h00);
		// reset in mid-programming leaves the fault flag
		key(8'h06);
		repeat (4) @(posedge clk_i);
		sys_reset_i <= 1'b1;
		@(posedge clk_i);
		sys_reset_i <= 1'b0;
		rd(CTL);
		chk("control", 32'h08, d);
		chk("stall", 0, {31'h0, core_stall_o});
		wr(CTL, 8'h01);
		@(negedge clk_i);
		chk("read_req", 1, {31'h0, read_req_o});
		@(negedge clk_i);
		chk("read_req", 0, {31'h0, read_req_o});
		conclude;
	end
endmodule
